// ===== rtl/iso_context_irq_bank.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iso_context_irq_bank
    import iso_irq_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // context requests, same clock domain
    input  wire ctx_req_type ctx_req,
    // summary and interrupt outputs
    output var  logic        tx_summary_event,
    output var  logic        rx_summary_event,
    output var  logic        irq
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    slave_state_type state;
    bus_phase_type   phase;
    ctx_req_type     req_prev;
    logic [7:0]      tx_context_events;
    logic [7:0]      tx_context_enables;
    logic [7:0]      rx_context_events;
    logic [7:0]      rx_context_enables;
    logic [1:0]      main_enable;      // [1] rx summary, [0] tx summary
    logic [1:0]      main_status;      // sticky summary events
    logic [7:0]      tx_rise;
    logic [7:0]      rx_rise;
    logic            accept;
    logic            wr_now;
    logic [7:0]      tx_ev_set_wr;     // decoded write strobes, one per register
    logic [7:0]      tx_ev_clr_wr;
    logic [7:0]      rx_ev_set_wr;
    logic [7:0]      rx_ev_clr_wr;
    logic [7:0]      tx_en_set_wr;
    logic [7:0]      tx_en_clr_wr;
    logic [7:0]      rx_en_set_wr;
    logic [7:0]      rx_en_clr_wr;

    // -------------------------------------------------------------------------
    // decode functions
    // -------------------------------------------------------------------------
    // byte lanes 0 of a written word, gated by an exact offset match
    function automatic logic [7:0] wr_bits(input logic          en,
                                           input logic [7:0]    off,
                                           input logic [7:0]    target,
                                           input logic [31:0]   data);
        wr_bits = (en && off == target) ? data[7:0] : 8'h00;
    endfunction : wr_bits

    // read mux; unmapped offsets and bits 31:8 read zero
    function automatic logic [31:0] rd_value(input logic [7:0] off,
                                             input logic [7:0] tev,
                                             input logic [7:0] ten,
                                             input logic [7:0] rev,
                                             input logic [7:0] ren,
                                             input logic [1:0] men,
                                             input logic [1:0] mst);
        logic [7:0] v;
        v = 8'h00;
        case (off)
            TX_EVENT_SET_OFF:   v = tev;
            TX_EVENT_CLEAR_OFF: v = tev & ten;
            TX_MASK_SET_OFF,
            TX_MASK_CLEAR_OFF:  v = ten;
            RX_EVENT_SET_OFF:   v = rev;
            RX_EVENT_CLEAR_OFF: v = rev & ren;
            RX_MASK_SET_OFF,
            RX_MASK_CLEAR_OFF:  v = ren;
            MAIN_ENABLE_OFF: begin
                v[TX_SUMMARY_BIT] = men[0];
                v[RX_SUMMARY_BIT] = men[1];
            end
            MAIN_STATUS_OFF: begin
                v[TX_SUMMARY_BIT] = mst[0];
                v[RX_SUMMARY_BIT] = mst[1];
            end
            default:            v = 8'h00;
        endcase
        rd_value = {24'h000000, v};
    endfunction : rd_value

    // -------------------------------------------------------------------------
    // ahb-lite slave
    // -------------------------------------------------------------------------
    // an address phase is taken only when the bus is ready and nonseq/seq
    assign accept = hsel && hready && htrans[1];
    assign wr_now = (state == S_WRITE) && phase.write;

    // reads take one wait state so a write just ahead is always visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= S_IDLE;
            phase     <= '0;
            hreadyout <= 1'b1;
        end else begin
            case (state)
                S_IDLE, S_RD_OUT, S_WRITE: begin
                    if (accept) begin
                        phase.offset <= {haddr[7:2], 2'b00};
                        phase.write  <= hwrite;
                        state        <= hwrite ? S_WRITE : S_RD_WAIT;
                        hreadyout    <= hwrite;
                    end else begin
                        state        <= S_IDLE;
                        hreadyout    <= 1'b1;
                    end
                end
                S_RD_WAIT: begin
                    state     <= S_RD_OUT;
                    hreadyout <= 1'b1;
                end
                default: begin
                    state     <= S_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // read data is latched at the end of the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (state == S_RD_WAIT) begin
            hrdata <= rd_value(phase.offset, tx_context_events, tx_context_enables,
                               rx_context_events, rx_context_enables, main_enable, main_status);
        end
    end

    // the slave never errors; unmapped accesses read zero and drop writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // write decode
    // -------------------------------------------------------------------------
    // decoded once as nets, so the logic and the assertions share one strobe
    assign tx_ev_set_wr = wr_bits(wr_now, phase.offset, TX_EVENT_SET_OFF, hwdata);
    assign tx_ev_clr_wr = wr_bits(wr_now, phase.offset, TX_EVENT_CLEAR_OFF, hwdata);
    assign rx_ev_set_wr = wr_bits(wr_now, phase.offset, RX_EVENT_SET_OFF, hwdata);
    assign rx_ev_clr_wr = wr_bits(wr_now, phase.offset, RX_EVENT_CLEAR_OFF, hwdata);
    assign tx_en_set_wr = wr_bits(wr_now, phase.offset, TX_MASK_SET_OFF, hwdata);
    assign tx_en_clr_wr = wr_bits(wr_now, phase.offset, TX_MASK_CLEAR_OFF, hwdata);
    assign rx_en_set_wr = wr_bits(wr_now, phase.offset, RX_MASK_SET_OFF, hwdata);
    assign rx_en_clr_wr = wr_bits(wr_now, phase.offset, RX_MASK_CLEAR_OFF, hwdata);

    // -------------------------------------------------------------------------
    // context request edge detection
    // -------------------------------------------------------------------------
    // engines pulse or hold their request; only the asserting edge counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_prev <= '0;
        end else begin
            req_prev <= ctx_req;
        end
    end

    assign tx_rise = ctx_req.tx & ~req_prev.tx;
    assign rx_rise = ctx_req.rx & ~req_prev.rx;

    // -------------------------------------------------------------------------
    // per-context event and enable bits
    // -------------------------------------------------------------------------
    // one slice per context; a set in the same cycle as a clear wins
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_ctx
            logic tx_set;
            logic tx_clr;
            logic rx_set;
            logic rx_clr;
            assign tx_set = tx_rise[gi] | tx_ev_set_wr[gi];
            assign tx_clr = tx_ev_clr_wr[gi];
            assign rx_set = rx_rise[gi] | rx_ev_set_wr[gi];
            assign rx_clr = rx_ev_clr_wr[gi];

            // bit gi is context gi, for both directions
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tx_context_events[gi] <= EVENT_RESET[gi];
                    rx_context_events[gi] <= EVENT_RESET[gi];
                end else begin
                    if (tx_set) begin
                        tx_context_events[gi] <= 1'b1;
                    end else if (tx_clr) begin
                        tx_context_events[gi] <= 1'b0;
                    end
                    if (rx_set) begin
                        rx_context_events[gi] <= 1'b1;
                    end else if (rx_clr) begin
                        rx_context_events[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // enables: ones at the set address set, ones at the clear address clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_context_enables <= ENABLE_RESET;
            rx_context_enables <= ENABLE_RESET;
        end else begin
            tx_context_enables <= (tx_context_enables | tx_en_set_wr) & ~tx_en_clr_wr;
            rx_context_enables <= (rx_context_enables | rx_en_set_wr) & ~rx_en_clr_wr;
        end
    end

    // -------------------------------------------------------------------------
    // summary events and interrupt
    // -------------------------------------------------------------------------
    // summaries are levels: they follow the masked events one cycle late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_summary_event <= 1'b0;
            rx_summary_event <= 1'b0;
        end else begin
            tx_summary_event <= |(tx_context_events & tx_context_enables);
            rx_summary_event <= |(rx_context_events & rx_context_enables);
        end
    end

    // main enable register, plain read/write of bits 7 and 6
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_enable <= MAIN_RESET;
        end else if (wr_now && phase.offset == MAIN_ENABLE_OFF) begin
            main_enable <= {hwdata[RX_SUMMARY_BIT], hwdata[TX_SUMMARY_BIT]};
        end
    end

    // sticky status, write one to clear; a live summary re-sets it at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_status <= MAIN_RESET;
        end else begin
            if (tx_summary_event) begin
                main_status[0] <= 1'b1;
            end else if (wr_now && phase.offset == MAIN_STATUS_OFF && hwdata[TX_SUMMARY_BIT]) begin
                main_status[0] <= 1'b0;
            end
            if (rx_summary_event) begin
                main_status[1] <= 1'b1;
            end else if (wr_now && phase.offset == MAIN_STATUS_OFF && hwdata[RX_SUMMARY_BIT]) begin
                main_status[1] <= 1'b0;
            end
        end
    end

    // level interrupt gated by the main enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(main_status & main_enable);
        end
    end

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_tx_edge_sets: assert property ((tx_rise != 8'h00) |=> ((tx_context_events & $past(tx_rise)) == $past(tx_rise)))
        else $error("tx request edge did not set its event bit");

    a_rx_edge_sets: assert property ((rx_rise != 8'h00) |=> ((rx_context_events & $past(rx_rise)) == $past(rx_rise)))
        else $error("rx request edge did not set its event bit");

    a_tx_clear_only: assert property (((~tx_context_events & $past(tx_context_events))
        & ~$past(tx_ev_clr_wr)) == 8'h00)
        else $error("tx event bit fell without a clear write");

    a_rx_clear_only: assert property (((~rx_context_events & $past(rx_context_events))
        & ~$past(rx_ev_clr_wr)) == 8'h00)
        else $error("rx event bit fell without a clear write");

    a_tx_raw_read: assert property ((state == S_RD_WAIT && phase.offset == TX_EVENT_SET_OFF)
        |=> hreadyout && hrdata == {24'h000000, $past(tx_context_events)})
        else $error("tx event set read not raw");

    a_tx_masked_read: assert property ((state == S_RD_WAIT && phase.offset == TX_EVENT_CLEAR_OFF)
        |=> hrdata == {24'h000000, $past(tx_context_events & tx_context_enables)})
        else $error("tx event clear read not masked");

    a_rx_masked_read: assert property ((state == S_RD_WAIT && phase.offset == RX_EVENT_CLEAR_OFF)
        |=> hrdata == {24'h000000, $past(rx_context_events & rx_context_enables)})
        else $error("rx event clear read not masked");

    a_mask_read: assert property ((state == S_RD_WAIT && phase.offset == RX_MASK_CLEAR_OFF)
        |=> hrdata[7:0] == $past(rx_context_enables) && hrdata[31:8] == 24'h000000)
        else $error("rx enable read wrong");

    a_read_wait: assert property ((accept && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");

    a_summary_or: assert property (tx_summary_event == $past(|(tx_context_events & tx_context_enables)))
        else $error("tx summary not or of masked events");

    a_irq_gate: assert property (irq |-> $past(|(main_status & main_enable)))
        else $error("irq without enabled summary status");

    a_rx_raw_read: assert property ((state == S_RD_WAIT && phase.offset == RX_EVENT_SET_OFF)
        |=> hrdata == {24'h000000, $past(rx_context_events)})
        else $error("rx event set read not raw");

    a_tx_mask_read: assert property ((state == S_RD_WAIT && (phase.offset == TX_MASK_SET_OFF
        || phase.offset == TX_MASK_CLEAR_OFF)) |=> hrdata == {24'h000000, $past(tx_context_enables)})
        else $error("tx enable read wrong");

    a_rx_summary_or: assert property (rx_summary_event == $past(|(rx_context_events & rx_context_enables)))
        else $error("rx summary not or of masked events");

    a_tx_bus_set: assert property ((tx_ev_set_wr != 8'h00)
        |=> ((tx_context_events & $past(tx_ev_set_wr)) == $past(tx_ev_set_wr)))
        else $error("tx event set write did not set its bits");

    a_rx_bus_set: assert property ((rx_ev_set_wr != 8'h00)
        |=> ((rx_context_events & $past(rx_ev_set_wr)) == $past(rx_ev_set_wr)))
        else $error("rx event set write did not set its bits");

    a_tx_enable_set: assert property ((tx_en_set_wr != 8'h00)
        |=> ((tx_context_enables & $past(tx_en_set_wr)) == $past(tx_en_set_wr)))
        else $error("tx enable set write did not set its bits");

    a_tx_enable_clear: assert property ((tx_en_clr_wr != 8'h00)
        |=> ((tx_context_enables & $past(tx_en_clr_wr)) == 8'h00))
        else $error("tx enable clear write did not clear its bits");

    a_rx_enable_set: assert property ((rx_en_set_wr != 8'h00)
        |=> ((rx_context_enables & $past(rx_en_set_wr)) == $past(rx_en_set_wr)))
        else $error("rx enable set write did not set its bits");

    a_rx_enable_clear: assert property ((rx_en_clr_wr != 8'h00)
        |=> ((rx_context_enables & $past(rx_en_clr_wr)) == 8'h00))
        else $error("rx enable clear write did not clear its bits");

    a_tx_mask_block: assert property (((tx_context_events & tx_context_enables) == 8'h00) |=> !tx_summary_event)
        else $error("masked tx event reached the summary");

    a_rx_mask_block: assert property (((rx_context_events & rx_context_enables) == 8'h00) |=> !rx_summary_event)
        else $error("masked rx event reached the summary");

    a_reserved_zero: assert property ((state == S_RD_OUT) |-> (hrdata[31:8] == 24'h000000))
        else $error("read data upper bits not zero");

    c_tx_event: cover property ((tx_rise != 8'h00) ##1 tx_summary_event);
    c_rx_clear: cover property (wr_now && phase.offset == RX_EVENT_CLEAR_OFF);
    c_irq_rise: cover property (!irq ##1 irq);
    c_read_back: cover property (state == S_RD_WAIT ##1 state == S_RD_OUT);
    c_irq_fall: cover property (irq ##1 !irq);

endmodule : iso_context_irq_bank
`default_nettype wire

// ===== rtl/iso_irq_pkg.sv
package iso_irq_pkg;

    // -------------------------------------------------------------------------
    // register offsets (byte addresses, low byte of haddr)
    // -------------------------------------------------------------------------
    localparam logic [7:0] TX_EVENT_SET_OFF   = 8'h90;
    localparam logic [7:0] TX_EVENT_CLEAR_OFF = 8'h94;
    localparam logic [7:0] TX_MASK_SET_OFF    = 8'h98;
    localparam logic [7:0] TX_MASK_CLEAR_OFF  = 8'h9c;
    localparam logic [7:0] RX_EVENT_SET_OFF   = 8'ha0;
    localparam logic [7:0] RX_EVENT_CLEAR_OFF = 8'ha4;
    localparam logic [7:0] RX_MASK_SET_OFF    = 8'ha8;
    localparam logic [7:0] RX_MASK_CLEAR_OFF  = 8'hac;
    localparam logic [7:0] MAIN_ENABLE_OFF    = 8'hb0;
    localparam logic [7:0] MAIN_STATUS_OFF    = 8'hb4;

    // -------------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------------
    localparam int         TX_SUMMARY_BIT     = 6;
    localparam int         RX_SUMMARY_BIT     = 7;
    localparam logic [7:0] EVENT_RESET        = 8'h00;
    localparam logic [7:0] ENABLE_RESET       = 8'h00;
    localparam logic [1:0] MAIN_RESET         = 2'h0;

    // context interrupt requests from the dma engines
    typedef struct packed {
        logic [7:0] rx;
        logic [7:0] tx;
    } ctx_req_type;

    // captured ahb address phase
    typedef struct packed {
        logic [7:0] offset;
        logic       write;
    } bus_phase_type;

    // bus slave states, gray along idle -> read wait -> read out
    typedef enum logic [1:0] {
        S_IDLE    = 2'b00,
        S_RD_WAIT = 2'b01,
        S_RD_OUT  = 2'b11,
        S_WRITE   = 2'b10
    } slave_state_type;

endpackage : iso_irq_pkg

// ===== test/iso_context_irq_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module iso_context_irq_bank_tb;
    import iso_irq_pkg::*;

    // -------------------------------------------------------------------------
    // signals
    // -------------------------------------------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    ctx_req_type ctx_req;
    logic        tx_summary_event;
    logic        rx_summary_event;
    logic        irq;
    int          errors;
    int          samples_checked;
    int          cycles = 0;

    iso_context_irq_bank dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .ctx_req(ctx_req), .tx_summary_event(tx_summary_event),
        .rx_summary_event(rx_summary_event), .irq(irq)
    );

    // free-running bus clock, 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // watchdog: the whole run needs well under this many cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            wrap_up();
        end
    end

    // -------------------------------------------------------------------------
    // bus and compare helpers
    // -------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // address phase held until hready, then data phase held until hready again
    task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus_xfer

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(a, 1'b1, d, q);
    endtask : bus_wr

    // read one word and judge it; the response code must always be okay
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus_xfer(a, 1'b0, 32'h00000000, q);
        check(what, q, exp);
        check("hresp", {31'h00000000, hresp}, 32'h00000000);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    // all registers clear after reset; a stray offset neither stores nor disturbs
    task automatic test_reset_values();
        logic [7:0] a;
        for (a = 8'h90; a <= 8'hb4; a += 8'h04) rd_chk(a, 32'h00000000, "reset_value");
        bus_wr(8'h80, 32'hffffffff);
        rd_chk(8'h80, 32'h00000000, "unmapped");
        rd_chk(8'h90, 32'h00000000, "unmapped_side_effect");
    endtask : test_reset_values

    // set and clear addresses of one event/enable pair, upper bits junk on purpose
    task automatic test_set_clear(input logic [7:0] base, input bit rx);
        bus_wr(base, 32'h1234ff5a);
        rd_chk(base, 32'h0000005a, "event_raw");
        rd_chk(base + 8'h04, 32'h00000000, "event_masked_off");
        bus_wr(base + 8'h08, 32'hffff000f);
        rd_chk(base + 8'h08, 32'h0000000f, "enable_at_set");
        rd_chk(base + 8'h0c, 32'h0000000f, "enable_at_clear");
        rd_chk(base + 8'h04, 32'h0000000a, "event_masked");
        check("summary_on", {31'h0, rx ? rx_summary_event : tx_summary_event}, 32'h1);
        check("irq_main_off", {31'h0, irq}, 32'h0);
        bus_wr(base + 8'h04, 32'h00000000);
        rd_chk(base, 32'h0000005a, "zero_clear");
        bus_wr(base + 8'h04, 32'hffff0052);
        rd_chk(base, 32'h00000008, "one_clear");
        bus_wr(base + 8'h0c, 32'hffff0008);
        rd_chk(base + 8'h08, 32'h00000007, "enable_clear");
        check("summary_off", {31'h0, rx ? rx_summary_event : tx_summary_event}, 32'h0);
        bus_wr(base + 8'h04, 32'h000000ff);
        bus_wr(base + 8'h0c, 32'h000000ff);
        rd_chk(base, 32'h00000000, "cleanup");
    endtask : test_set_clear

    // each request line lands on its own bit; a request held high sets only once
    task automatic test_context_edges();
        logic [7:0] base;
        for (int side = 0; side < 2; side++) begin
            for (int n = 0; n < 8; n++) begin
                base = (side == 1) ? 8'ha0 : 8'h90;
                if (side == 1) ctx_req.rx[n] <= 1'b1;
                else ctx_req.tx[n] <= 1'b1;
                @(posedge hclk);
                rd_chk(base, 32'h00000001 << n, "context_bit");
                bus_wr(base + 8'h04, 32'h000000ff);
                rd_chk(base, 32'h00000000, "held_request");
                ctx_req <= '0;
                @(posedge hclk);
            end
        end
    endtask : test_context_edges

    // full path from context request to the processor interrupt
    task automatic test_irq_path();
        bus_wr(8'hb4, 32'h000000c0);
        bus_wr(8'h98, 32'h00000008);
        bus_wr(8'hb0, 32'h00000040);
        ctx_req.tx[3] <= 1'b1;
        @(posedge hclk);
        ctx_req <= '0;
        tick(5);
        check("tx_summary", {31'h0, tx_summary_event}, 32'h1);
        check("irq_tx", {31'h0, irq}, 32'h1);
        rd_chk(8'hb4, 32'h00000040, "main_status");
        rd_chk(8'h90, 32'h00000008, "which_context");
        bus_wr(8'h94, 32'h00000008);
        tick(2); // let the summary fall before clearing status, or it re-sets
        bus_wr(8'hb4, 32'h000000c0);
        bus_wr(8'ha0, 32'h00000001);
        bus_wr(8'hb0, 32'h000000c0);
        tick(5);
        check("rx_blocked", {31'h0, rx_summary_event}, 32'h0);
        check("irq_blocked", {31'h0, irq}, 32'h0);
        bus_wr(8'ha8, 32'h00000001);
        tick(5);
        check("rx_passed", {31'h0, rx_summary_event}, 32'h1);
        check("irq_rx", {31'h0, irq}, 32'h1);
        bus_wr(8'hb0, 32'h00000040);
        tick(3);
        check("irq_main_gated", {31'h0, irq}, 32'h0);
        bus_wr(8'ha4, 32'h000000ff);
        bus_wr(8'hac, 32'h000000ff);
        bus_wr(8'h9c, 32'h000000ff);
    endtask : test_irq_path

    // -------------------------------------------------------------------------
    // closing report and main sequence
    // -------------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        errors = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        ctx_req = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset_values();
        test_set_clear(8'h90, 1'b0);
        test_set_clear(8'ha0, 1'b1);
        test_context_edges();
        test_irq_path();
        wrap_up();
    end
endmodule : iso_context_irq_bank_tb
`default_nettype wire
